// [verification/tel_event_latches_props.sv]
// Assertions on the host read port and the counter wrap latch.
// Assumes only the top module ports; bound to every instance below.
module tel_event_latches_props (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic host_sel_i,
   input wire logic host_rd_i,
   input wire logic [4:0] host_addr_i,
   input wire logic [7:0] host_data_o,
   input wire logic host_data_oe_o,
   input wire tel_pkg::tel_counters_t counters_i
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   // =====
   // Wrap tracking
   // Wraps since the last latch read; age keeps reads close to a wrap out of the check.
   logic req;
   logic on_wrap;
   logic [63:0] prev;
   logic [7:0] wrap;
   logic [7:0] pend;
   logic [2:0] age;
   assign req = host_sel_i && host_rd_i;
   assign on_wrap = host_data_oe_o && host_addr_i == tel_pkg::COUNTER_WRAP_LATCH_ADDR;
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         wrap[i] = prev[8*i +: 8] == 8'hff && counters_i[8*i +: 8] == 8'h00;
   end
   // A wrap seen while a read is open is dropped here, so the check only gets weaker.
   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         prev <= 64'h0;
         pend <= 8'h00;
         age <= 3'h0;
      end
      else
      begin
         prev <= counters_i;
         age <= (|wrap) ? 3'h0 : ((age == 3'h7) ? age : age + 3'h1);
         pend <= on_wrap ? 8'h00 : (pend | wrap);
      end
   end
   // =====
   // Properties
   property p_oe_rise; $rose(req) |-> ##[2:5] $rose(host_data_oe_o); endproperty
   property p_oe_fall; $fell(req) |-> ##[2:5] !host_data_oe_o; endproperty
   property p_oe_hold; req [*5] |-> host_data_oe_o; endproperty
   property p_unmapped;
      $rose(host_data_oe_o) && host_addr_i != 5'h1e && host_addr_i != 5'h1f |-> host_data_o == 8'h00;
   endproperty
   property p_idle; (!req) [*4] |=> $stable(host_data_o); endproperty
   property p_once; host_data_oe_o && $past(host_data_oe_o) |-> $stable(host_data_o); endproperty
   property p_reset; $fell(reset_i) |-> host_data_o == 8'h00 && !host_data_oe_o; endproperty
   property p_wrap; $rose(on_wrap) && age >= 3'h2 |-> (host_data_o & pend) == pend; endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("drive enable late");
   a_oe_fall: assert property (p_oe_fall) else $error("drive enable stuck");
   a_oe_hold: assert property (p_oe_hold) else $error("drive enable dropped");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_idle: assert property (p_idle) else $error("read data moved while idle");
   a_once: assert property (p_once) else $error("held strobe read twice");
   a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
   a_wrap: assert property (p_wrap) else $error("wrap not latched");
   c_flags: cover property ($rose(host_data_oe_o) && host_addr_i == 5'h1e);
   c_wrap: cover property ($rose(on_wrap) && host_data_o != 8'h00);
   c_unmapped: cover property ($rose(host_data_oe_o) && host_addr_i == 5'h05);
endmodule // tel_event_latches_props

bind tel_event_latches tel_event_latches_props u_props (.mclk_i, .reset_i, .host_sel_i, .host_rd_i,
   .host_addr_i, .host_data_o, .host_data_oe_o, .counters_i);

// [verification/tel_event_latches_tb.sv]
// Self-checking bench for the T1 event flags and counter wrap latch.
// Assumes tel_pkg and the design are compiled first; the checker is bound.
module tel_event_latches_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HOLD = 20;
   localparam logic [4:0] F = tel_pkg::EVENT_FLAGS_THREE_ADDR;
   localparam logic [4:0] W = tel_pkg::COUNTER_WRAP_LATCH_ADDR;
   logic mclk_i = 1'b0, reset_i = 1'b1, sel = 1'b0, rd = 1'b0, oe;
   logic c0 = 1'b0, c1 = 1'b0, c2 = 1'b0, lu = 1'b0, ld = 1'b0, s1 = 1'b0, s5 = 1'b0, msg = 1'b0, deb = 1'b0;
   logic [4:0] addr = 5'h00;
   bit loop_up = 1'b0;
   logic [5:0] code = 6'h00;
   logic [7:0] mask = 8'hff, rdat;
   logic [95:0] sig = 96'h0;
   tel_pkg::tel_counters_t cnt = 64'h0;
   // Each row is mask, events fired, flags expected.
   logic [23:0] rows [11] = '{24'hff8080, 24'hff4040, 24'hff2020, 24'hff1010, 24'hff1010, 24'hff0808,
      24'hff0404, 24'hff0202, 24'hff0101, 24'h00ff00, 24'h5aff5a};
   int n_errors = 0, comparisons = 0;

   always #20 mclk_i = ~mclk_i;

   tel_event_latches #(.LOOP_HOLD(HOLD), .DEBOUNCE(8)) dut (.mclk_i(mclk_i), .reset_i(reset_i),
      .host_sel_i(sel), .host_rd_i(rd), .host_addr_i(addr), .host_data_o(rdat), .host_data_oe_o(oe),
      .event_mask_i(mask), .link_ctrl0_event_i(c0), .link_ctrl1_event_i(c1), .link_ctrl2_event_i(c2),
      .loop_up_match_i(lu), .loop_down_match_i(ld), .one_second_tick_status_i(s1),
      .five_second_tick_status_i(s5), .facility_data_link_msg_i(msg), .facility_data_link_code_i(code),
      .signalling_bits_i(sig), .signalling_debounce_enable_i(deb), .counters_i(cnt));

   // =====
   // Tasks
   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cyc(int n);
      repeat (n) @(negedge mclk_i);
   endtask

   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One host read; hit raises a controller event at the very edge that clears the flags.
   task automatic expect_rd(string what, logic [4:0] a, bit hit, logic [7:0] exp);
      int k;
      k = 0;
      addr = a;
      cyc(2);
      sel = 1'b1;
      rd = 1'b1;
      cyc(2);
      c0 = hit;
      cyc(1);
      c0 = 1'b0;
      while (oe !== 1'b1 && k < 8)
      begin
         cyc(1);
         k++;
      end
      // A read that never gets its drive enable is a failure in its own right.
      if (k == 8)
      begin
         n_errors++;
         $display("BAD %s drive enable expected 1 seen %b", what, oe);
         report_and_stop();
      end
      else
      begin
         chk(what, exp, rdat);
         sel = 1'b0;
         rd = 1'b0;
         cyc(6);
      end
   endtask

   task automatic strobe(logic [5:0] c, int n);
      repeat (n)
      begin
         code = c;
         msg = 1'b1;
         cyc(1);
         msg = 1'b0;
         cyc(1);
      end
   endtask

   // Fires the chosen events; the loop code alternates between its up and down patterns.
   task automatic fire(logic [7:0] ev);
      {c0, c1, c2, s1, s5} = {ev[7:5], ev[3:2]};
      if (ev[0])
         sig = ~sig;
      cyc(1);
      {c0, c1, c2} = 3'h0;
      cyc(2);
      {s1, s5} = 2'h0;
      lu = ev[4] & loop_up;
      ld = ev[4] & ~loop_up;
      if (ev[4])
         loop_up = ~loop_up;
      cyc(HOLD + 4);
      {lu, ld} = 2'h0;
      if (ev[1])
         strobe(code + 6'h01, 8);
   endtask

   // =====
   // Main sequence
   initial
   begin
      cyc(12);
      reset_i = 1'b0;
      expect_rd("flags reset", F, 0, tel_pkg::FLAGS_RESET);
      expect_rd("wrap reset", W, 0, 8'h00);
      foreach (rows[i])
      begin
         mask = rows[i][23:16];
         fire(rows[i][15:8]);
         expect_rd("flags", F, 0, rows[i][7:0]);
         expect_rd("flags cleared", F, 0, 8'h00);
      end
      mask = 8'hff;
      expect_rd("flags at event", F, 1, 8'h00);
      expect_rd("flags kept", F, 0, 8'h80);
      fire(8'h08);
      expect_rd("unmapped", 5'h05, 0, 8'h00);
      expect_rd("flags after unmapped", F, 0, 8'h08);
      // A loop code that drops out before the hold time must not be reported.
      lu = 1'b1;
      cyc(HOLD - 2);
      lu = 1'b0;
      expect_rd("short loop", F, 0, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         foreach (rows[j])
            if (j < 4)
            begin
               cnt[63 - 8*i -: 8] = (j == 0) ? 8'hfe : ((j == 2) ? 8'hff : 8'h00);
               cyc(1);
            end
         expect_rd("wrap", W, 0, 8'h80 >> i);
         expect_rd("wrap cleared", W, 0, 8'h00);
      end
      strobe(6'h2a, 7);
      strobe(6'h31, 3);
      expect_rd("seven of ten", F, 0, 8'h00);
      strobe(6'h2a, 8);
      expect_rd("eight of ten", F, 0, 8'h02);
      strobe(6'h2a, 8);
      expect_rd("same message", F, 0, 8'h00);
      deb = 1'b1;
      sig[0] = ~sig[0];
      cyc(3);
      sig[0] = ~sig[0];
      cyc(12);
      expect_rd("glitch", F, 0, 8'h00);
      sig[0] = ~sig[0];
      cyc(12);
      expect_rd("debounced", F, 0, 8'h01);
      fire(8'h80);
      sig = 96'h0;
      reset_i = 1'b1;
      cyc(3);
      reset_i = 1'b0;
      expect_rd("flags second reset", F, 0, 8'h00);
      report_and_stop();
   end
endmodule // tel_event_latches_tb

// [verilog/tel_event_latches.sv]
// Event flag register and counter-wrap latch register for T1 mode.
// Assumes the host pins are asynchronous to mclk_i and the event, mask and
// counter inputs come from logic on mclk_i.
module tel_event_latches #(
   parameter int LOOP_HOLD = tel_pkg::LOOP_HOLD_CYCLES,
   parameter int DEBOUNCE = tel_pkg::DEBOUNCE_CYCLES,
   parameter int SIG_W = 96
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic host_sel_i,
   input wire logic host_rd_i,
   input wire logic [4:0] host_addr_i,
   output logic [7:0] host_data_o,
   output logic host_data_oe_o,
   input wire logic [7:0] event_mask_i,
   input wire logic link_ctrl0_event_i,
   input wire logic link_ctrl1_event_i,
   input wire logic link_ctrl2_event_i,
   input wire logic loop_up_match_i,
   input wire logic loop_down_match_i,
   input wire logic one_second_tick_status_i,
   input wire logic five_second_tick_status_i,
   input wire logic facility_data_link_msg_i,
   input wire logic [5:0] facility_data_link_code_i,
   input wire logic [SIG_W-1:0] signalling_bits_i,
   input wire logic signalling_debounce_enable_i,
   input wire tel_pkg::tel_counters_t counters_i
);

   localparam int LW = $clog2(LOOP_HOLD + 1);
   localparam int DW = $clog2(DEBOUNCE + 1);

   // ==========================================================
   // Host port synchronisers
   // Two flops on every pin; only the second stage is read.
   logic sel_s1, sel_s2, rd_s1, rd_s2, rd_seen;
   logic [4:0] addr_s1, addr_s2;
   logic read_go, read_flags, read_wraps;

   // Pins pass two flops before any decode looks at them.
   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sel_s1 <= 1'b0;
         sel_s2 <= 1'b0;
         rd_s1 <= 1'b0;
         rd_s2 <= 1'b0;
         addr_s1 <= 5'h00;
         addr_s2 <= 5'h00;
         rd_seen <= 1'b0;
      end
      else
      begin
         sel_s1 <= host_sel_i;
         sel_s2 <= sel_s1;
         rd_s1 <= host_rd_i;
         rd_s2 <= rd_s1;
         addr_s1 <= host_addr_i;
         addr_s2 <= addr_s1;
         rd_seen <= sel_s2 & rd_s2;
      end
   end

   // One pulse per read access, on the first cycle select and read are both seen.
   assign read_go = sel_s2 & rd_s2 & ~rd_seen;
   assign read_flags = read_go & (addr_s2 == tel_pkg::EVENT_FLAGS_THREE_ADDR);
   assign read_wraps = read_go & (addr_s2 == tel_pkg::COUNTER_WRAP_LATCH_ADDR);

   // ==========================================================
   // Status edge detection
   logic one_sec_d, five_sec_d;
   logic one_sec_rise, five_sec_rise;

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         one_sec_d <= 1'b0;
         five_sec_d <= 1'b0;
      end
      else
      begin
         one_sec_d <= one_second_tick_status_i;
         five_sec_d <= five_second_tick_status_i;
      end
   end

   assign one_sec_rise = one_second_tick_status_i & ~one_sec_d;
   assign five_sec_rise = five_second_tick_status_i & ~five_sec_d;

   // ==========================================================
   // Loop code persistence timer
   // Fires once per continuous presence, so a held code does not refire.
   logic [LW-1:0] loop_count;
   logic loop_fired;
   logic loop_present, loop_event;
   assign loop_present = loop_up_match_i | loop_down_match_i;

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         loop_count <= '0;
         loop_fired <= 1'b0;
      end
      else if (!loop_present)
      begin
         loop_count <= '0;
         loop_fired <= 1'b0;
      end
      else if (loop_count == LW'(LOOP_HOLD - 1))
      begin
         loop_fired <= 1'b1;
      end
      else
      begin
         loop_count <= loop_count + LW'(1);
      end
   end
   assign loop_event = loop_present & (loop_count == LW'(LOOP_HOLD - 1)) & ~loop_fired;

   // ==========================================================
   // Bit oriented message voting
   // The framer delivers the six free bits of each 11111110xxxxxx0 pattern with a strobe.
   logic [tel_pkg::MSG_CODE_W-1:0] msg_hist [tel_pkg::MSG_HISTORY];
   logic [tel_pkg::MSG_CODE_W-1:0] msg_accepted;
   logic msg_have;
   logic [3:0] vote_count;
   logic msg_event;
   // Count how many of the ten positions, the new one included, hold the new code.
   always_comb
   begin
      vote_count = 4'h1;
      for (int i = 0; i < tel_pkg::MSG_HISTORY - 1; i++)
      begin
         if (msg_hist[i] == facility_data_link_code_i)
            vote_count = vote_count + 4'h1;
      end
   end
   assign msg_event = facility_data_link_msg_i & (vote_count >= 4'(tel_pkg::MSG_VOTES))
      & (!msg_have | (facility_data_link_code_i != msg_accepted));
   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         for (int i = 0; i < tel_pkg::MSG_HISTORY; i++)
            msg_hist[i] <= '1;
         msg_accepted <= '0;
         msg_have <= 1'b0;
      end
      else if (facility_data_link_msg_i)
      begin
         msg_hist[0] <= facility_data_link_code_i;
         for (int i = 1; i < tel_pkg::MSG_HISTORY; i++)
            msg_hist[i] <= msg_hist[i-1];
         if (msg_event)
         begin
            msg_accepted <= facility_data_link_code_i;
            msg_have <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Signalling change detection
   // One debounce timer serves all channels: cheap, but any bit that keeps
   // moving holds back reporting of the others until the line settles.
   logic [SIG_W-1:0] sig_cand, sig_stable;
   logic [DW-1:0] deb_count;
   logic [SIG_W-1:0] next_sig_stable;
   logic sig_event;
   always_comb
   begin
      next_sig_stable = sig_stable;
      if (!signalling_debounce_enable_i)
         next_sig_stable = signalling_bits_i;
      else if (signalling_bits_i == sig_cand && deb_count == DW'(DEBOUNCE - 1))
         next_sig_stable = sig_cand;
   end
   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sig_cand <= '0;
         sig_stable <= '0;
         deb_count <= '0;
      end
      else
      begin
         sig_cand <= signalling_bits_i;
         sig_stable <= next_sig_stable;
         if (signalling_bits_i != sig_cand)
            deb_count <= '0;
         else if (deb_count != DW'(DEBOUNCE - 1))
            deb_count <= deb_count + DW'(1);
      end
   end
   assign sig_event = next_sig_stable != sig_stable;

   // ==========================================================
   // Counter wrap detection
   tel_pkg::tel_counters_t counters_d;
   logic [7:0] wrap_event;
   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
         counters_d <= '0;
      else
         counters_d <= counters_i;
   end
   // Bit 7 is the first counter of the struct, bit 0 the last.
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         wrap_event[i] = (counters_d[i*8 +: 8] == tel_pkg::COUNT_ALL_ONES)
            & (counters_i[i*8 +: 8] == tel_pkg::COUNT_ZERO);
      end
   end

   // ==========================================================
   // Flag registers
   logic [7:0] event_flags_three, counter_wrap_latch;
   logic [7:0] flag_event;
   always_comb
   begin
      flag_event = 8'h00;
      flag_event[tel_pkg::LINK_CTRL0_BIT] = link_ctrl0_event_i;
      flag_event[tel_pkg::LINK_CTRL1_BIT] = link_ctrl1_event_i;
      flag_event[tel_pkg::LINK_CTRL2_BIT] = link_ctrl2_event_i;
      flag_event[tel_pkg::LOOP_PATTERN_BIT] = loop_event;
      flag_event[tel_pkg::ONE_SECOND_BIT] = one_sec_rise;
      flag_event[tel_pkg::FIVE_SECOND_BIT] = five_sec_rise;
      flag_event[tel_pkg::BIT_MESSAGE_BIT] = msg_event;
      flag_event[tel_pkg::SIGNALLING_BIT] = sig_event;
   end
   // A set in the clearing cycle wins, so no event slips past a read.
   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
         event_flags_three <= tel_pkg::FLAGS_RESET;
      else
         event_flags_three <= (event_flags_three & ~{8{read_flags}})
            | (flag_event & event_mask_i);
   end
   // The wrap latch is never masked.
   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
         counter_wrap_latch <= tel_pkg::FLAGS_RESET;
      else
         counter_wrap_latch <= (counter_wrap_latch & ~{8{read_wraps}}) | wrap_event;
   end

   // ==========================================================
   // Read data
   // Data is captured at the start of the access and held until the next one.
   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         host_data_o <= 8'h00;
         host_data_oe_o <= 1'b0;
      end
      else
      begin
         host_data_oe_o <= sel_s2 & rd_s2;
         if (read_flags)
            host_data_o <= event_flags_three;
         else if (read_wraps)
            host_data_o <= counter_wrap_latch;
         else if (read_go)
            host_data_o <= 8'h00;
      end
   end

endmodule // tel_event_latches

// [verilog/tel_pkg.sv]
// Package for the T1 event and counter-wrap latch block.
// Assumes one 25 MHz clock and an 8-bit non-multiplexed host port.
package tel_pkg;

   // ==========================================================
   // Register map
   localparam logic [4:0] EVENT_FLAGS_THREE_ADDR = 5'h1e;
   localparam logic [4:0] COUNTER_WRAP_LATCH_ADDR = 5'h1f;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   // ==========================================================
   // Bit positions in event_flags_three
   localparam int LINK_CTRL0_BIT = 7;
   localparam int LINK_CTRL1_BIT = 6;
   localparam int LINK_CTRL2_BIT = 5;
   localparam int LOOP_PATTERN_BIT = 4;
   localparam int ONE_SECOND_BIT = 3;
   localparam int FIVE_SECOND_BIT = 2;
   localparam int BIT_MESSAGE_BIT = 1;
   localparam int SIGNALLING_BIT = 0;

   // ==========================================================
   // Counter wrap detection: all ones falling back to zero
   localparam logic [7:0] COUNT_ALL_ONES = 8'hff;
   localparam logic [7:0] COUNT_ZERO = 8'h00;

   // ==========================================================
   // Bit oriented message voting
   localparam int MSG_HISTORY = 10;
   localparam int MSG_VOTES = 8;
   localparam int MSG_CODE_W = 6;

   // ==========================================================
   // Timing
   localparam int CLOCK_KHZ = 25000;
   localparam int LOOP_HOLD_MS = 48;
   localparam int LOOP_HOLD_CYCLES = LOOP_HOLD_MS * CLOCK_KHZ;
   localparam int DEBOUNCE_MS = 6;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLOCK_KHZ;

   // Values of the eight performance counters, bit 7 down to bit 0 of the latch.
   typedef struct packed {
      logic [7:0] framing_error;
      logic [7:0] crc_error;
      logic [7:0] out_of_frame;
      logic [7:0] alignment_change;
      logic [7:0] line_violation;
      logic [7:0] test_pattern_error;
      logic [7:0] test_pattern_multiframe;
      logic [7:0] multiframe_sync_loss;
   } tel_counters_t;

endpackage
